// >>> rtl/pms_pkg.sv
// Shared constants and types for the power monitor serial link
package pms_pkg;

  // ************************************************************
  // Bus address
  // ************************************************************
  localparam logic [2:0] ADDR_HI = 3'h7;
  localparam logic [1:0] ADDR_LO = 2'h2;
  localparam logic [3:0] BITS_PER_BYTE = 4'h8;
  localparam int RES_W = 12;

  // ************************************************************
  // Command byte fields
  // ************************************************************
  localparam int C_VCONT = 0;
  localparam int C_VONCE = 1;
  localparam int C_ICONT = 2;
  localparam int C_IONCE = 3;
  localparam int C_VRANGE = 4;
  localparam int C_STAT = 6;
  localparam int C_EXT = 7;

  // ************************************************************
  // Host registers (APB byte addresses)
  // ************************************************************
  localparam logic [11:0] REG_DIV = 12'h000;
  localparam logic [11:0] REG_CMD = 12'h004;
  localparam logic [11:0] REG_STAT = 12'h008;
  localparam int CMD_START = 8;
  localparam int CMD_STOP = 9;
  localparam int CMD_READ = 10;
  localparam int CMD_NACK = 11;
  localparam int CMD_W = 12;
  localparam int STAT_BUSY = 0;
  localparam int STAT_ACK = 1;
  localparam int STAT_RDATA = 8;

  // ************************************************************
  // Timing
  // ************************************************************
  localparam int SYS_CLK_HZ = 250000000;
  localparam int SCL_MAX_HZ = 400000;
  // Quarter of an SCL period, rounded up so SCL never exceeds the limit
  localparam int QTR_CYCLES = (SYS_CLK_HZ + 4 * SCL_MAX_HZ - 1) / (4 * SCL_MAX_HZ);
  localparam int DIV_W = 16;

  // ************************************************************
  // State encodings
  // ************************************************************
  typedef enum logic [6:0] {
    DS_IDLE = 7'h01, DS_ADDR = 7'h02, DS_AACK = 7'h04, DS_WR = 7'h08,
    DS_WACK = 7'h10, DS_RD = 7'h20, DS_RACK = 7'h40
  } pms_dev_st_t;
  typedef enum logic [2:0] {CV_IDLE = 3'h1, CV_VOLT = 3'h2, CV_CURR = 3'h4} pms_conv_st_t;
  typedef enum logic [3:0] {
    HS_IDLE = 4'h1, HS_START = 4'h2, HS_BIT = 4'h4, HS_STOP = 4'h8
  } pms_host_st_t;
endpackage

// >>> rtl/pms_i2c_if.sv
// Two-wire bus carrier joining host and device ends
`timescale 1ns/1ns
`default_nettype none
interface pms_i2c_if;
  logic scl_o;
  logic scl_oe_n;
  logic m_sda_o;
  logic m_sda_oe_n;
  logic s_sda_o;
  logic s_sda_oe_n;
  logic scl;
  logic sda;

  // ************************************************************
  // Wired-AND with pull-up
  // ************************************************************
  assign scl = scl_oe_n ? 1'b1 : scl_o;
  assign sda = (m_sda_oe_n ? 1'b1 : m_sda_o) & (s_sda_oe_n ? 1'b1 : s_sda_o);

  modport host (output scl_o, scl_oe_n, m_sda_o, m_sda_oe_n, input scl, sda);
  modport dev (output s_sda_o, s_sda_oe_n, input scl, sda);
endinterface
`default_nettype wire

// >>> rtl/pms_i2c_dev.sv
// Device end: bus slave with command decode and conversion sequencing
//
// Overview of operation
// - Answer address 111, select bits, 10
// - Select pin state gives middle two bits
// - Bus works up to 400 kHz
// - Master starts, sends address MSB first, direction
// - Direction 0 writes, 1 reads
// - Matching address acknowledged, others ignored
// - Nine clocks per byte including acknowledge
// - SDA changes only while SCL low; stop
// - First written byte is the command
// - Master writes command before reading
// - Master ends write with stop
// - Master ends read with no-acknowledge, stop
// - Voltage or current into 12-bit converter
// - Conversion command accepted at any time
// - Command MSB selects control or extended write
// - Single-shot pending refuses reads; bit self-clears
// - Continuous mode early read returns zeros
//
// Our own choices: the placing of the registers and the APB register port.
`timescale 1ns/1ns
`default_nettype none
module pms_i2c_dev (
  // Clock and reset
  input wire logic link_clk,
  input wire logic rst,
  // Bus
  pms_i2c_if.dev link,
  // Address select pin, decoded four-state level
  input wire logic [1:0] adr_sel,
  // Converter
  output logic adc_start,
  output logic adc_chan,
  input wire logic adc_done,
  input wire logic [pms_pkg::RES_W-1:0] adc_data,
  output logic volt_range,
  // Status and extended registers
  input wire logic [7:0] status_byte,
  output logic ext_wr_stb,
  output logic [1:0] ext_wr_addr,
  output logic [7:0] ext_wr_data
);

  typedef struct packed {
    pms_pkg::pms_dev_st_t st;
    pms_pkg::pms_conv_st_t cst;
    logic scl_s1;
    logic scl_s2;
    logic scl_d;
    logic sda_s1;
    logic sda_s2;
    logic sda_d;
    logic [1:0] adr_s1;
    logic [1:0] adr_s2;
    logic [3:0] cnt;
    logic [7:0] sh;
    logic rw;
    logic [1:0] idx;
    logic ext_pend;
    logic [1:0] ext_addr;
    logic [6:0] ctrl;
    logic sel_v;
    logic sel_i;
    logic sda_oe_n;
    logic [pms_pkg::RES_W-1:0] v_res;
    logic [pms_pkg::RES_W-1:0] i_res;
    logic adc_start;
    logic adc_chan;
    logic ext_wr_stb;
    logic [7:0] ext_wr_data;
  } pms_dev_state_t;

  pms_dev_state_t r_reg;
  pms_dev_state_t r_next;

  // ************************************************************
  // Read byte selection
  // ************************************************************
  function automatic logic [7:0] rd_byte(input logic [1:0] idx, input logic stat,
                                         input logic sv, input logic si,
                                         input logic [7:0] sb,
                                         input logic [pms_pkg::RES_W-1:0] v,
                                         input logic [pms_pkg::RES_W-1:0] i);
    logic [pms_pkg::RES_W-1:0] one;
    one = si ? i : v;
    rd_byte = 8'h00;
    if (stat) begin
      rd_byte = (idx == 2'h0) ? sb : 8'h00;
    end else if (sv && si) begin
      // Three bytes: both high parts, then both low nibbles
      case (idx)
        2'h0: rd_byte = v[11:4];
        2'h1: rd_byte = i[11:4];
        2'h2: rd_byte = {v[3:0], i[3:0]};
        default: rd_byte = 8'h00;
      endcase
    end else begin
      case (idx)
        2'h0: rd_byte = one[11:4];
        2'h1: rd_byte = {one[3:0], 4'h0};
        default: rd_byte = 8'h00;
      endcase
    end
  endfunction

  // ************************************************************
  // Next state
  // ************************************************************
  always_comb begin
    logic scl_rise;
    logic scl_fall;
    logic start_c;
    logic stop_c;
    logic busy;
    logic v_req;
    logic i_req;
    logic [6:0] my_addr;
    logic [7:0] rb;
    r_next = r_reg;
    r_next.adc_start = 1'b0;
    r_next.ext_wr_stb = 1'b0;
    r_next.scl_s1 = link.scl;
    r_next.scl_s2 = r_reg.scl_s1;
    r_next.scl_d = r_reg.scl_s2;
    r_next.sda_s1 = link.sda;
    r_next.sda_s2 = r_reg.sda_s1;
    r_next.sda_d = r_reg.sda_s2;
    r_next.adr_s1 = adr_sel;
    r_next.adr_s2 = r_reg.adr_s1;
    scl_rise = r_reg.scl_s2 & ~r_reg.scl_d;
    scl_fall = ~r_reg.scl_s2 & r_reg.scl_d;
    start_c = r_reg.scl_s2 & r_reg.scl_d & r_reg.sda_d & ~r_reg.sda_s2;
    stop_c = r_reg.scl_s2 & r_reg.scl_d & ~r_reg.sda_d & r_reg.sda_s2;
    busy = r_reg.ctrl[pms_pkg::C_VONCE] | r_reg.ctrl[pms_pkg::C_IONCE];
    v_req = r_reg.ctrl[pms_pkg::C_VCONT] | r_reg.ctrl[pms_pkg::C_VONCE];
    i_req = r_reg.ctrl[pms_pkg::C_ICONT] | r_reg.ctrl[pms_pkg::C_IONCE];
    my_addr = {pms_pkg::ADDR_HI, r_reg.adr_s2, pms_pkg::ADDR_LO};
    rb = 8'h00;

    // Conversion sequencer; voltage first, then current if asked
    case (r_reg.cst)
      pms_pkg::CV_IDLE: begin
        if (v_req) begin
          r_next.adc_start = 1'b1;
          r_next.adc_chan = 1'b0;
          r_next.cst = pms_pkg::CV_VOLT;
        end else if (i_req) begin
          r_next.adc_start = 1'b1;
          r_next.adc_chan = 1'b1;
          r_next.cst = pms_pkg::CV_CURR;
        end
      end
      pms_pkg::CV_VOLT: begin
        if (adc_done) begin
          r_next.v_res = adc_data;
          r_next.ctrl[pms_pkg::C_VONCE] = 1'b0;
          if (i_req) begin
            r_next.adc_start = 1'b1;
            r_next.adc_chan = 1'b1;
            r_next.cst = pms_pkg::CV_CURR;
          end else begin
            r_next.cst = pms_pkg::CV_IDLE;
          end
        end
      end
      pms_pkg::CV_CURR: begin
        if (adc_done) begin
          r_next.i_res = adc_data;
          r_next.ctrl[pms_pkg::C_IONCE] = 1'b0;
          r_next.cst = pms_pkg::CV_IDLE;
        end
      end
      default: r_next.cst = pms_pkg::CV_IDLE;
    endcase

    // Bus engine; sampling on SCL rise, driving on SCL fall
    case (r_reg.st)
      pms_pkg::DS_ADDR: begin
        if (scl_rise) begin
          r_next.sh = {r_reg.sh[6:0], r_reg.sda_s2};
          r_next.cnt = r_reg.cnt + 4'h1;
        end
        if (scl_fall && r_reg.cnt == pms_pkg::BITS_PER_BYTE) begin
          // Reads are refused while a single-shot is pending
          if (r_reg.sh[7:1] == my_addr && !(r_reg.sh[0] && busy)) begin
            r_next.sda_oe_n = 1'b0;
            r_next.rw = r_reg.sh[0];
            r_next.st = pms_pkg::DS_AACK;
          end else begin
            r_next.st = pms_pkg::DS_IDLE;
          end
        end
      end
      pms_pkg::DS_AACK: begin
        if (scl_fall) begin
          r_next.cnt = 4'h0;
          r_next.idx = 2'h0;
          if (r_reg.rw) begin
            rb = rd_byte(2'h0, r_reg.ctrl[pms_pkg::C_STAT], r_reg.sel_v, r_reg.sel_i,
                         status_byte, r_reg.v_res, r_reg.i_res);
            r_next.sh = rb;
            r_next.sda_oe_n = rb[7];
            r_next.st = pms_pkg::DS_RD;
          end else begin
            r_next.sda_oe_n = 1'b1;
            r_next.ext_pend = 1'b0;
            r_next.st = pms_pkg::DS_WR;
          end
        end
      end
      pms_pkg::DS_WR: begin
        if (scl_rise) begin
          r_next.sh = {r_reg.sh[6:0], r_reg.sda_s2};
          r_next.cnt = r_reg.cnt + 4'h1;
        end
        if (scl_fall && r_reg.cnt == pms_pkg::BITS_PER_BYTE) begin
          r_next.sda_oe_n = 1'b0;
          r_next.cnt = 4'h0;
          r_next.st = pms_pkg::DS_WACK;
          if (r_reg.idx != 2'h3) begin
            r_next.idx = r_reg.idx + 2'h1;
          end
          if (r_reg.idx == 2'h0) begin
            if (r_reg.sh[pms_pkg::C_EXT]) begin
              r_next.ext_pend = 1'b1;
              r_next.ext_addr = r_reg.sh[1:0];
            end else begin
              // Command wins over a self-clear in the same cycle
              r_next.ctrl = r_reg.sh[6:0];
              r_next.sel_v = r_reg.sh[pms_pkg::C_VCONT] | r_reg.sh[pms_pkg::C_VONCE];
              r_next.sel_i = r_reg.sh[pms_pkg::C_ICONT] | r_reg.sh[pms_pkg::C_IONCE];
              r_next.v_res = '0;
              r_next.i_res = '0;
            end
          end else if (r_reg.ext_pend) begin
            r_next.ext_wr_stb = 1'b1;
            r_next.ext_wr_data = r_reg.sh;
            r_next.ext_pend = 1'b0;
          end
        end
      end
      pms_pkg::DS_WACK: begin
        if (scl_fall) begin
          r_next.sda_oe_n = 1'b1;
          r_next.st = pms_pkg::DS_WR;
        end
      end
      pms_pkg::DS_RD: begin
        if (scl_rise) begin
          r_next.cnt = r_reg.cnt + 4'h1;
        end
        if (scl_fall) begin
          if (r_reg.cnt == pms_pkg::BITS_PER_BYTE) begin
            r_next.sda_oe_n = 1'b1;
            r_next.st = pms_pkg::DS_RACK;
          end else if (r_reg.cnt != 4'h0) begin
            r_next.sh = {r_reg.sh[6:0], 1'b0};
            r_next.sda_oe_n = r_reg.sh[6];
          end
        end
      end
      pms_pkg::DS_RACK: begin
        if (scl_rise) begin
          if (r_reg.sda_s2) begin
            r_next.st = pms_pkg::DS_IDLE;
          end else if (r_reg.idx != 2'h3) begin
            r_next.idx = r_reg.idx + 2'h1;
          end
        end else if (scl_fall) begin
          rb = rd_byte(r_reg.idx, r_reg.ctrl[pms_pkg::C_STAT], r_reg.sel_v, r_reg.sel_i,
                       status_byte, r_reg.v_res, r_reg.i_res);
          r_next.sh = rb;
          r_next.sda_oe_n = rb[7];
          r_next.cnt = 4'h0;
          r_next.st = pms_pkg::DS_RD;
        end
      end
      pms_pkg::DS_IDLE: r_next.sda_oe_n = 1'b1;
      default: r_next.st = pms_pkg::DS_IDLE;
    endcase

    if (start_c) begin
      r_next.st = pms_pkg::DS_ADDR;
      r_next.cnt = 4'h0;
      r_next.sda_oe_n = 1'b1;
    end else if (stop_c) begin
      r_next.st = pms_pkg::DS_IDLE;
      r_next.sda_oe_n = 1'b1;
    end
  end

  // ************************************************************
  // State register
  // ************************************************************
  always_ff @(posedge link_clk) begin
    if (rst) begin
      r_reg <= '0;
      r_reg.st <= pms_pkg::DS_IDLE;
      r_reg.cst <= pms_pkg::CV_IDLE;
      // Idle-high sync reset avoids a false start after reset
      r_reg.scl_s1 <= 1'b1;
      r_reg.scl_s2 <= 1'b1;
      r_reg.scl_d <= 1'b1;
      r_reg.sda_s1 <= 1'b1;
      r_reg.sda_s2 <= 1'b1;
      r_reg.sda_d <= 1'b1;
      r_reg.sda_oe_n <= 1'b1;
    end else begin
      r_reg <= r_next;
    end
  end

  assign link.s_sda_o = 1'b0;
  assign link.s_sda_oe_n = r_reg.sda_oe_n;
  assign adc_start = r_reg.adc_start;
  assign adc_chan = r_reg.adc_chan;
  assign volt_range = r_reg.ctrl[pms_pkg::C_VRANGE];
  assign ext_wr_stb = r_reg.ext_wr_stb;
  assign ext_wr_addr = r_reg.ext_addr;
  assign ext_wr_data = r_reg.ext_wr_data;
endmodule // pms_i2c_dev
`default_nettype wire

// >>> rtl/pms_i2c_host.sv
// Host end: APB-controlled bus master that makes SCL from sys_clk
`timescale 1ns/1ns
`default_nettype none
module pms_i2c_host #(
  parameter logic [pms_pkg::DIV_W-1:0] QTR_DEFAULT = pms_pkg::DIV_W'(pms_pkg::QTR_CYCLES)
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Bus
  pms_i2c_if.host link
);

  typedef struct packed {
    pms_pkg::pms_host_st_t st;
    logic [pms_pkg::DIV_W-1:0] cnt;
    logic [pms_pkg::DIV_W-1:0] div;
    logic [1:0] ph;
    logic [3:0] bitn;
    logic [7:0] sh;
    logic [pms_pkg::CMD_W-1:0] cmd;
    logic scl_oe_n;
    logic sda_oe_n;
    logic sda_s1;
    logic sda_s2;
    logic ack_seen;
    logic [31:0] prdata;
  } pms_host_state_t;

  pms_host_state_t r_reg;
  pms_host_state_t r_next;
  logic acc;
  logic mapped;

  assign acc = psel & penable;
  assign mapped = (paddr == pms_pkg::REG_DIV) || (paddr == pms_pkg::REG_CMD) ||
                  (paddr == pms_pkg::REG_STAT);

  // ************************************************************
  // Next state
  // ************************************************************
  always_comb begin
    logic tick;
    logic rd;
    r_next = r_reg;
    r_next.sda_s1 = link.sda;
    r_next.sda_s2 = r_reg.sda_s1;
    rd = r_reg.cmd[pms_pkg::CMD_READ];
    tick = 1'b0;

    // Read data is fetched in the setup cycle so it comes from a flop
    if (psel && !penable) begin
      if (paddr == pms_pkg::REG_DIV) begin
        r_next.prdata = {{(32 - pms_pkg::DIV_W){1'b0}}, r_reg.div};
      end else if (paddr == pms_pkg::REG_CMD) begin
        r_next.prdata = {{(32 - pms_pkg::CMD_W){1'b0}}, r_reg.cmd};
      end else if (paddr == pms_pkg::REG_STAT) begin
        r_next.prdata = {16'h0000, r_reg.sh, 6'h00, r_reg.ack_seen,
                         r_reg.st != pms_pkg::HS_IDLE};
      end else begin
        r_next.prdata = 32'h0000_0000;
      end
    end

    if (r_reg.st != pms_pkg::HS_IDLE) begin
      if (r_reg.cnt + 1'b1 >= r_reg.div) begin
        tick = 1'b1;
        r_next.cnt = '0;
        r_next.ph = r_reg.ph + 2'h1;
      end else begin
        r_next.cnt = r_reg.cnt + 1'b1;
      end
    end

    // Four quarters per bit: set data, raise SCL, sample, lower SCL
    case (r_reg.st)
      pms_pkg::HS_START: begin
        if (tick) begin
          case (r_reg.ph)
            2'h0: r_next.sda_oe_n = 1'b1;
            2'h1: r_next.scl_oe_n = 1'b1;
            2'h2: r_next.sda_oe_n = 1'b0;
            default: begin
              r_next.scl_oe_n = 1'b0;
              r_next.bitn = 4'h0;
              r_next.st = pms_pkg::HS_BIT;
            end
          endcase
        end
      end
      pms_pkg::HS_BIT: begin
        if (tick) begin
          case (r_reg.ph)
            2'h0: begin
              if (r_reg.bitn < pms_pkg::BITS_PER_BYTE) begin
                r_next.sda_oe_n = rd ? 1'b1 : r_reg.sh[7];
              end else begin
                r_next.sda_oe_n = rd ? r_reg.cmd[pms_pkg::CMD_NACK] : 1'b1;
              end
            end
            2'h1: r_next.scl_oe_n = 1'b1;
            2'h2: begin
              if (r_reg.bitn < pms_pkg::BITS_PER_BYTE) begin
                r_next.sh = {r_reg.sh[6:0], r_reg.sda_s2};
              end else begin
                r_next.ack_seen = ~r_reg.sda_s2;
              end
            end
            default: begin
              r_next.scl_oe_n = 1'b0;
              r_next.bitn = r_reg.bitn + 4'h1;
              if (r_reg.bitn == pms_pkg::BITS_PER_BYTE) begin
                r_next.st = r_reg.cmd[pms_pkg::CMD_STOP] ? pms_pkg::HS_STOP : pms_pkg::HS_IDLE;
              end
            end
          endcase
        end
      end
      pms_pkg::HS_STOP: begin
        if (tick) begin
          case (r_reg.ph)
            2'h0: r_next.sda_oe_n = 1'b0;
            2'h1: r_next.scl_oe_n = 1'b1;
            2'h2: r_next.sda_oe_n = 1'b1;
            default: r_next.st = pms_pkg::HS_IDLE;
          endcase
        end
      end
      pms_pkg::HS_IDLE: r_next.cnt = '0;
      default: r_next.st = pms_pkg::HS_IDLE;
    endcase

    if (acc && pwrite && mapped) begin
      if (paddr == pms_pkg::REG_DIV) begin
        r_next.div = pwdata[pms_pkg::DIV_W-1:0];
      end else if (paddr == pms_pkg::REG_CMD && r_reg.st == pms_pkg::HS_IDLE) begin
        // A command while busy is dropped
        r_next.cmd = pwdata[pms_pkg::CMD_W-1:0];
        r_next.sh = pwdata[7:0];
        r_next.ph = 2'h0;
        r_next.cnt = '0;
        r_next.bitn = 4'h0;
        r_next.ack_seen = 1'b0;
        r_next.st = pwdata[pms_pkg::CMD_START] ? pms_pkg::HS_START : pms_pkg::HS_BIT;
      end
    end
  end

  // ************************************************************
  // State register
  // ************************************************************
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      r_reg <= '0;
      r_reg.st <= pms_pkg::HS_IDLE;
      r_reg.div <= QTR_DEFAULT;
      r_reg.scl_oe_n <= 1'b1;
      r_reg.sda_oe_n <= 1'b1;
      r_reg.sda_s1 <= 1'b1;
      r_reg.sda_s2 <= 1'b1;
    end else begin
      r_reg <= r_next;
    end
  end

  assign link.scl_o = 1'b0;
  assign link.scl_oe_n = r_reg.scl_oe_n;
  assign link.m_sda_o = 1'b0;
  assign link.m_sda_oe_n = r_reg.sda_oe_n;
  assign prdata = r_reg.prdata;
  assign pready = 1'b1;
  assign pslverr = acc & ~mapped;
endmodule // pms_i2c_host
`default_nettype wire

// >>> testbench/pms_checker.sv
// Wire-level checks on the two-wire link between host and device
`timescale 1ns/1ns
`default_nettype none
module pms_checker #(
  parameter int QTR = 100
) (
  // Clocks and reset
  input wire logic sys_clk,
  input wire logic link_clk,
  input wire logic rst,
  // Link wires
  input wire logic scl_o,
  input wire logic scl_oe_n,
  input wire logic m_sda_o,
  input wire logic m_sda_oe_n,
  input wire logic s_sda_o,
  input wire logic s_sda_oe_n,
  input wire logic scl,
  input wire logic sda
);
  int hi_cnt;
  int lo_cnt;
  int rise_cnt;
  // Rises since start; a stop lands on the tenth pulse of a byte
  always_ff @(posedge sys_clk) begin
    hi_cnt <= scl ? hi_cnt + 1 : 0;
    lo_cnt <= scl ? 0 : lo_cnt + 1;
    if (rst || (scl && $fell(sda))) begin
      rise_cnt <= 0;
    end else if ($rose(scl)) begin
      rise_cnt <= rise_cnt + 1;
    end
  end
  property p_open_drain;
    @(posedge sys_clk) disable iff (rst) !scl_o && !m_sda_o && !s_sda_o;
  endproperty
  a_open_drain: assert property (p_open_drain)
    else $error("link driven high");
  property p_addr_quiet;
    @(posedge sys_clk) disable iff (rst) !s_sda_oe_n |-> rise_cnt >= 8;
  endproperty
  a_addr_quiet: assert property (p_addr_quiet)
    else $error("device drove sda during address");
  property p_dev_edge;
    @(posedge link_clk) disable iff (rst) $changed(s_sda_oe_n) |-> !scl;
  endproperty
  a_dev_edge: assert property (p_dev_edge)
    else $error("device moved sda with scl high");
  property p_ack_hold;
    @(posedge sys_clk) disable iff (rst) $rose(scl) && !s_sda_oe_n |=> !s_sda_oe_n until !scl;
  endproperty
  a_ack_hold: assert property (p_ack_hold)
    else $error("device released sda in scl high");
  property p_scl_hi;
    @(posedge sys_clk) disable iff (rst)
      $fell(scl) && rise_cnt != 0 |-> hi_cnt >= 2 * QTR - 2 && hi_cnt <= 2 * QTR + 2;
  endproperty
  a_scl_hi: assert property (p_scl_hi)
    else $error("scl high time wrong");
  property p_scl_lo;
    @(posedge sys_clk) disable iff (rst)
      // Idle gaps between commands may hold SCL low longer
      $rose(scl) |-> lo_cnt >= 2 * QTR - 2 && (rise_cnt % 9 == 0 || lo_cnt <= 2 * QTR + 2);
  endproperty
  a_scl_lo: assert property (p_scl_lo)
    else $error("scl low time wrong");
  property p_start_hold;
    @(posedge sys_clk) disable iff (rst) scl && $fell(sda) |-> scl [*8];
  endproperty
  a_start_hold: assert property (p_start_hold)
    else $error("start not held");
  property p_stop_hold;
    @(posedge sys_clk) disable iff (rst) scl && $rose(sda) |-> sda [*8];
  endproperty
  a_stop_hold: assert property (p_stop_hold)
    else $error("sda dropped after stop");
  property p_nine;
    @(posedge sys_clk) disable iff (rst) scl && $rose(sda) |-> rise_cnt % 9 == 1;
  endproperty
  a_nine: assert property (p_nine)
    else $error("stop off the byte grid");
endmodule // pms_checker
`default_nettype wire

// >>> testbench/testbench.sv
// Self-checking bench: APB-driven host talking to the device end
`timescale 1ns/1ns
`default_nettype none
module testbench;
  localparam int QTR = 100;
  localparam logic [7:0] AW = 8'hfc;
  localparam logic [7:0] AR = 8'hfd;
  logic sys_clk = 1'b0;
  logic link_clk = 1'b0;
  logic rst = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic [1:0] adr_sel = 2'h0;
  logic adc_start;
  logic adc_chan;
  logic adc_done = 1'b0;
  logic [11:0] adc_data = 12'h000;
  logic volt_range;
  logic [7:0] status_byte = 8'h5c;
  logic ext_wr_stb;
  logic [1:0] ext_wr_addr;
  logic [7:0] ext_wr_data;
  logic [9:0] ext_seen = 10'h000;
  logic chan_q = 1'b0;
  int adc_cnt = 0;
  int adc_lat = 400;
  int err_total = 0;
  int n_tests = 0;
  logic [31:0] rd;
  logic slv;
  pms_i2c_if link ();
  always #2 sys_clk = ~sys_clk;
  always #32 link_clk = ~link_clk;
  pms_i2c_host #(.QTR_DEFAULT(16'(QTR))) i_pms_i2c_host (.sys_clk(sys_clk), .rst(rst),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .link(link.host));
  pms_i2c_dev i_pms_i2c_dev (.link_clk(link_clk), .rst(rst), .link(link.dev),
    .adr_sel(adr_sel), .adc_start(adc_start), .adc_chan(adc_chan), .adc_done(adc_done),
    .adc_data(adc_data), .volt_range(volt_range), .status_byte(status_byte),
    .ext_wr_stb(ext_wr_stb), .ext_wr_addr(ext_wr_addr), .ext_wr_data(ext_wr_data));
  pms_checker #(.QTR(QTR)) i_pms_checker (.sys_clk(sys_clk), .link_clk(link_clk),
    .rst(rst), .scl_o(link.scl_o), .scl_oe_n(link.scl_oe_n), .m_sda_o(link.m_sda_o),
    .m_sda_oe_n(link.m_sda_oe_n), .s_sda_o(link.s_sda_o), .s_sda_oe_n(link.s_sda_oe_n),
    .scl(link.scl), .sda(link.sda));
  // ************************************************************
  // Converter stand-in, deliberately slow to expose early reads
  // ************************************************************
  always @(posedge link_clk) begin
    adc_done <= 1'b0;
    if (adc_start === 1'b1) begin
      adc_cnt <= adc_lat;
      chan_q <= adc_chan;
    end else if (adc_cnt == 1) begin
      adc_done <= 1'b1;
      adc_data <= chan_q ? 12'h123 : 12'habc;
      adc_cnt <= 0;
    end else if (adc_cnt > 1) begin
      adc_cnt <= adc_cnt - 1;
    end
    if (ext_wr_stb === 1'b1) begin
      ext_seen <= {ext_wr_addr, ext_wr_data};
    end
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      err_total++;
      $display("ERROR %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    do @(posedge sys_clk); while (pready !== 1'b1);
    rd = prdata;
    slv = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // Flags: 0 start, 1 stop, 2 read, 3 no-ack; leaves the final status in rd
  task automatic xfer(input logic [3:0] fl, input logic [7:0] b);
    int k;
    apb(1'b1, pms_pkg::REG_CMD, {20'h0, fl, b});
    k = 0;
    repeat (2) @(posedge sys_clk);
    rd = 32'h1;
    while (rd[0] !== 1'b0 && k < 4000) begin
      apb(1'b0, pms_pkg::REG_STAT, 32'h0);
      k++;
    end
    // A hung transfer counts as a mismatch
    if (rd[0] !== 1'b0) begin
      err_total++;
    end
  endtask
  task automatic wrap_up();
    $display("checks %0d errors %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  initial begin
    #400000;
    err_total++;
    wrap_up();
  end
  // ************************************************************
  // Tests
  // ************************************************************
  initial begin
    // Reset spans six link clocks so both domains see it
    repeat (96) @(posedge sys_clk);
    rst <= 1'b0;
    apb(1'b0, pms_pkg::REG_DIV, 32'h0);
    chk(rd, 32'(QTR));
    apb(1'b1, pms_pkg::REG_DIV, 32'h0001_1234);
    apb(1'b0, pms_pkg::REG_DIV, 32'h0);
    chk(rd, 32'h0000_1234);
    apb(1'b1, pms_pkg::REG_DIV, 32'(QTR));
    apb(1'b0, 12'h00c, 32'h0);
    chk(rd | {31'h0, slv}, 32'h1);
    for (int s = 0; s < 4; s++) begin
      adr_sel <= s[1:0];
      xfer(4'h3, {3'h7, s[1:0], 3'h4});
      chk(rd & 32'hff03, {16'h0, 3'h7, s[1:0], 3'h4, 8'h02});
    end
    xfer(4'h3, 8'he4);
    chk(rd & 32'hff03, 32'h0000e400);
    xfer(4'h1, AW);
    xfer(4'h2, 8'h12);
    chk(32'(volt_range), 32'h1);
    xfer(4'h3, AR);
    chk(rd & 32'hff03, 32'h0000fd00);
    repeat (1000) @(posedge sys_clk);
    xfer(4'h1, AR);
    chk(rd & 32'hff03, 32'h0000fd02);
    xfer(4'h4, 8'hff);
    chk(rd & 32'hff00, 32'h0000ab00);
    xfer(4'he, 8'hff);
    chk(rd & 32'hff00, 32'h0000c000);
    adc_lat = 1000;
    xfer(4'h1, AW);
    xfer(4'h2, 8'h05);
    xfer(4'h1, AR);
    chk(rd & 32'hff03, 32'h0000fd02);
    xfer(4'he, 8'hff);
    chk(rd & 32'hff00, 32'h0);
    xfer(4'h1, AW);
    xfer(4'h0, 8'h81);
    xfer(4'h2, 8'h5a);
    chk(32'(ext_seen), 32'h15a);
    xfer(4'h1, AW);
    xfer(4'h2, 8'h40);
    xfer(4'h1, AR);
    chk(rd & 32'hff03, 32'h0000fd02);
    xfer(4'he, 8'hff);
    chk(rd & 32'hff00, 32'h00005c00);
    wrap_up();
  end
endmodule // testbench
`default_nettype wire
